/* File: bench/shp_peer.sv */
`timescale 1ns/1ps
module shp_peer(
  input wire logic clk,
  input wire logic go,
  input wire logic out_full_n,
  input wire logic [7:0] pa,
  output logic strobe_n = 1,
  output logic ack_n = 1,
  output logic [7:0] pin = 8'h5a,
  output logic [7:0] got
);
  // Pins held past strobe rise to cover sync delay
  always @(posedge go)
  begin
    repeat (3) @(posedge clk); strobe_n <= 0; repeat (4) @(posedge clk); strobe_n <= 1;
    repeat (4) @(posedge clk); pin <= ~pin;
  end
  // Slow ack after output-full; data taken on its rise
  always @(negedge out_full_n)
  begin
    repeat (3) @(posedge clk); ack_n <= 0;
  end
  always @(posedge out_full_n)
  begin
    got <= pa; ack_n <= 1;
  end
endmodule : shp_peer

/* File: bench/shp_port_ctrl_properties.sv */
`timescale 1ns/1ps
module shp_chk(
  input wire logic clk,
  input wire logic rst,
  input wire logic ack_n_a,
  input wire logic input_full_a,
  input wire logic output_full_n_a,
  input wire logic irq_request_a
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ack_held; !ack_n_a [*3]; endsequence
  sequence s_flags_idle; !irq_request_a && !input_full_a && output_full_n_a; endsequence
  property p_rst; disable iff (1'b0) rst |=> s_flags_idle; endproperty
  a_rst: assert property (p_rst) else $error("flags after reset");
  property p_out_full; s_ack_held |=> output_full_n_a; endproperty
  a_out_full: assert property (p_out_full) else $error("output full stuck");
  property p_irq; $rose(irq_request_a) |-> input_full_a || output_full_n_a; endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_out_rise; $rose(output_full_n_a) |-> $past(!ack_n_a); endproperty
  a_out_rise: assert property (p_out_rise) else $error("output full freed without ack");
  property p_full_first; $rose(input_full_a) |-> !$rose(irq_request_a); endproperty
  a_full_first: assert property (p_full_first) else $error("irq before strobe end");
  property p_rst_rel; disable iff (1'b0) $fell(rst) |-> s_flags_idle; endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("flags at reset release");
endmodule : shp_chk
bind shp_port_ctrl shp_chk u_shp_chk(.*);

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, go = 0, go_b = 0;
  logic input_strobe_n_b, ack_n_b, wb_ack, input_strobe_n_a, ack_n_a, input_full_a;
  logic output_full_n_a, irq_request_a, input_full_b, output_full_n_b, irq_request_b;
  logic [7:0] wb_adr = 0, pb_in, pa_in, pa_out, pa_oe, pb_out, pb_oe, got, got_b;
  logic [31:0] wb_dat_wr = 0, wb_dat_rd, q;
  logic [3:0] wb_sel = 4'hf;
  int fails = 0, checks_done = 0;
  always #25 clk = ~clk;
  shp_port_ctrl u_shp_port_ctrl(.*);
  shp_peer u_shp_peer(.clk, .go, .out_full_n(output_full_n_a), .pa(pa_out),
    .strobe_n(input_strobe_n_a), .ack_n(ack_n_a), .pin(pa_in), .got);
  shp_peer u_shp_peer_b(.clk, .go(go_b), .out_full_n(output_full_n_b), .pa(pb_out),
    .strobe_n(input_strobe_n_b), .ack_n(ack_n_b), .pin(pb_in), .got(got_b));
  task ck(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin fails++; $display("mismatch %0t seen %h expected %h", $time, s, e); end
  endtask : ck
  task results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // Classic cycle, held until ack, bounded wait
  task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk); {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_wr} <= {2'b11, w, a, v}; n = 0;
    do @(posedge clk); while (wb_ack !== 1 && ++n < 40);
    q = wb_dat_rd; {wb_cyc, wb_stb} <= 2'b00; if (n > 39) begin fails++; results; end
  endtask : wb
  task t_in;
    wb(1, 8'h0c, 32'hb0); wb(1, 8'h0c, 32'h09); go <= 1; repeat (16) @(posedge clk);
    ck({input_full_a, irq_request_a}, 3);
    wb(0, 8'h00, 0); go <= 0; repeat (8) @(posedge clk);
    ck({q[7:0], input_full_a, irq_request_a}, 32'h5a << 2);
    $display("input done");
  endtask : t_in
  task t_out;
    wb(1, 8'h0c, 32'ha0); wb(1, 8'h0c, 32'h0d); wb(1, 8'h00, 32'h3c); repeat (16) @(posedge clk);
    ck({got, output_full_n_a, irq_request_a}, 32'h3c << 2 | 3);
    $display("output done");
  endtask : t_out
  // Bidirectional: ack-caused irq, then strobe; read after write clears both
  task t_bidir;
    wb(1, 8'h0c, 32'hc0); wb(1, 8'h0c, 32'h09); wb(1, 8'h0c, 32'h0d); wb(1, 8'h00, 32'h81);
    repeat (16) @(posedge clk);
    ck({got, irq_request_a, pa_oe}, 32'h81 << 9 | 32'h100);
    go <= 1; repeat (16) @(posedge clk);
    ck({input_full_a, irq_request_a}, 3);
    wb(0, 8'h00, 0); go <= 0; repeat (4) @(posedge clk);
    ck({q[7:0], input_full_a, irq_request_a}, 32'ha5 << 2);
    $display("bidir done");
  endtask : t_bidir
  // Group B strobed input, status word, then port read
  task t_grp_b;
    wb(1, 8'h0c, 32'h86); wb(1, 8'h0c, 32'h05); go_b <= 1; repeat (16) @(posedge clk);
    ck({input_full_b, irq_request_b, pb_oe}, 32'h300);
    wb(0, 8'h08, 0);
    ck(q[7:0], 32'h87);
    wb(0, 8'h04, 0); repeat (4) @(posedge clk);
    ck({q[7:0], input_full_b, irq_request_b}, 32'h5a << 2);
    $display("group b done");
  endtask : t_grp_b
  initial
  begin
    repeat (2) @(posedge clk); rst <= 0; @(negedge clk);
    ck({irq_request_a, input_full_a, output_full_n_a}, 1);
    t_in; t_out; t_bidir; t_grp_b; results;
  end
endmodule : testbench

/* File: design/shp_pkg.sv */
package shp_pkg;

  // ==========================================
  // Operating mode of one group
  typedef enum logic [1:0] {
    SHP_MODE_BASIC,
    SHP_MODE_STROBED,
    SHP_MODE_BIDIR
  } shp_mode_type;

  // ==========================================
  // Handshake state of one data port
  typedef struct packed {
    logic [7:0] in_lat;
    logic [7:0] out_lat;
    logic in_full;
    logic out_full_n;
    logic strobe_src;
    logic ack_src;
    logic wr_done;
  } shp_group_type;

  // ==========================================
  // Whole state of the port controller
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    shp_mode_type mode_a;
    logic a_input;
    shp_mode_type mode_b;
    logic b_input;
    logic irq_en_a_in;
    logic irq_en_a_out;
    logic irq_en_b;
    shp_group_type grp_a;
    shp_group_type grp_b;
  } shp_state_type;

endpackage : shp_pkg

/* File: design/shp_port_ctrl.sv */
`timescale 1ns/1ps
`include "shp_regs.svh"

// Overview of operation
// RULE1 - Strobed mode: two groups, port plus control slice
// RULE2 - Each port input or output, both latched
// RULE3 - Low input strobe captures pins into latch
// RULE4 - Input-full set by strobe, cleared read rise
// RULE5 - Input irq: strobe rise sets, read fall clears
// RULE6 - Enables written by bit set/reset: 4,6,2
// RULE7 - Output-full low on write rise, ack clears
// RULE8 - Output data valid by output-full rise
// RULE9 - Peripheral drives ack low when ready
// RULE10 - Peripheral latches data on output-full rise
// RULE11 - Output irq: ack rise sets, write fall clears
// RULE12 - Bidirectional mode for group A only
// RULE13 - Bidir irq from ack or strobe rise, enabled
// RULE14 - Bidir irq cleared by matching host strobe
// RULE15 - Bidir output-full low after host write
// RULE16 - Bidir port A drives only while ack low
// RULE17 - Bidir output enable set at bit six
// RULE18 - Bidir input-full high after strobed capture
// RULE19 - Irq suppressed unless its enable is set
// RULE20 - Mode selection and reset clear all enables
// RULE21 - Bidir input enable set at bit four
// RULE22 - Pin strobes synchronised, edges detected
// RULE23 - Handshake flags inactive after reset

module shp_port_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_wr,
  output logic [31:0] wb_dat_rd,
  output logic wb_ack,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  input wire logic input_strobe_n_a,
  input wire logic ack_n_a,
  input wire logic input_strobe_n_b,
  input wire logic ack_n_b,
  output logic input_full_a,
  output logic output_full_n_a,
  output logic irq_request_a,
  output logic input_full_b,
  output logic output_full_n_b,
  output logic irq_request_b
);

  // ==========================================
  // Registered state and its next value
  shp_pkg::shp_state_type q;
  shp_pkg::shp_state_type d;

  // ==========================================
  // Pin strobe synchronisers
  logic [3:0] pin_raw;
  logic [3:0] pin_level;
  logic [3:0] pin_rise;

  // Fixed line order: strobe A, ack A, strobe B, ack B
  assign pin_raw = {ack_n_b, input_strobe_n_b, ack_n_a, input_strobe_n_a};

  // Peripheral pins move at any time, so every line is synchronised here and its rise taken; falls are left open [RULE22]
  shp_sync_edge #(
    .W(4)
  ) u_shp_sync_edge (
    .clk(clk),
    .rst(rst),
    .raw(pin_raw),
    .level(pin_level),
    .rise(pin_rise),
    .fall()
  );

  logic strobe_low_a;
  logic strobe_rise_a;
  logic ack_low_a;
  logic ack_rise_a;
  logic strobe_low_b;
  logic strobe_rise_b;
  logic ack_low_b;
  logic ack_rise_b;

  // Named views of the synchronised lines
  assign strobe_low_a = ~pin_level[0];
  assign strobe_rise_a = pin_rise[0];
  assign ack_low_a = ~pin_level[1];
  assign ack_rise_a = pin_rise[1];
  assign strobe_low_b = ~pin_level[2];
  assign strobe_rise_b = pin_rise[2];
  assign ack_low_b = ~pin_level[3];
  assign ack_rise_b = pin_rise[3];

  // ==========================================
  // Host bus events
  logic bus_req;
  logic bus_first;
  logic bus_last;
  logic hit_a;
  logic hit_b;
  logic hit_ctrl;
  logic [7:0] host_byte;
  logic rd_fall_a;
  logic rd_rise_a;
  logic wr_fall_a;
  logic wr_rise_a;
  logic rd_fall_b;
  logic rd_rise_b;
  logic wr_fall_b;
  logic wr_rise_b;
  logic ctrl_wr;

  // Request start stands for the strobe fall, the acked cycle for its rise
  assign bus_req = wb_cyc & wb_stb;
  assign bus_first = bus_req & ~q.ack;
  assign bus_last = bus_req & q.ack;
  assign hit_a = (wb_adr == `SHP_OFF_PORT_A);
  assign hit_b = (wb_adr == `SHP_OFF_PORT_B);
  assign hit_ctrl = (wb_adr == `SHP_OFF_CTRL);
  assign host_byte = wb_dat_wr[7:0];

  // Only byte lane 0 carries data; the upper lanes are ignored
  assign rd_fall_a = bus_first & ~wb_we & hit_a;
  assign rd_rise_a = bus_last & ~wb_we & hit_a;
  assign wr_fall_a = bus_first & wb_we & wb_sel[0] & hit_a;
  assign wr_rise_a = bus_last & wb_we & wb_sel[0] & hit_a;
  assign rd_fall_b = bus_first & ~wb_we & hit_b;
  assign rd_rise_b = bus_last & ~wb_we & hit_b;
  assign wr_fall_b = bus_first & wb_we & wb_sel[0] & hit_b;
  assign wr_rise_b = bus_last & wb_we & wb_sel[0] & hit_b;
  assign ctrl_wr = bus_last & wb_we & wb_sel[0] & hit_ctrl;

  // ==========================================
  // Mode views
  logic a_bidir;
  logic a_in_path;
  logic a_out_path;
  logic b_in_path;
  logic b_out_path;

  // Group A: strobed input, strobed output or both at once [RULE1] [RULE2] [RULE12]
  assign a_bidir = (q.mode_a == shp_pkg::SHP_MODE_BIDIR);
  assign a_in_path = a_bidir | ((q.mode_a == shp_pkg::SHP_MODE_STROBED) & q.a_input);
  assign a_out_path = a_bidir | ((q.mode_a == shp_pkg::SHP_MODE_STROBED) & ~q.a_input);

  // Group B has no bidirectional path [RULE12]
  assign b_in_path = (q.mode_b == shp_pkg::SHP_MODE_STROBED) & q.b_input;
  assign b_out_path = (q.mode_b == shp_pkg::SHP_MODE_STROBED) & ~q.b_input;

  // ==========================================
  // Interrupt clear terms of group A
  logic both_src_a;
  logic clr_strobe_a;
  logic clr_ack_a;

  // Both causes pending: a host strobe after a write pulse clears both [RULE14]
  assign both_src_a = q.grp_a.strobe_src & q.grp_a.ack_src;
  assign clr_strobe_a = rd_fall_a | (a_bidir & both_src_a & wr_fall_a & q.grp_a.wr_done);
  assign clr_ack_a = wr_fall_a | (a_bidir & both_src_a & rd_fall_a & q.grp_a.wr_done);

  // ==========================================
  // Interrupt outputs, gated by the live enables [RULE19]
  assign irq_request_a = (q.grp_a.strobe_src & q.irq_en_a_in & a_in_path)
    | (q.grp_a.ack_src & q.irq_en_a_out & a_out_path);
  assign irq_request_b = (q.grp_b.strobe_src & q.irq_en_b & b_in_path)
    | (q.grp_b.ack_src & q.irq_en_b & b_out_path);

  // ==========================================
  // Read path
  logic [7:0] status_byte;
  logic [7:0] ctrl_byte;
  logic [7:0] rd_byte;

  // Status word: flags and enables of both groups
  assign status_byte[`SHP_ST_IRQ_B] = irq_request_b;
  assign status_byte[`SHP_ST_FULL_B] = q.b_input ? q.grp_b.in_full : q.grp_b.out_full_n;
  assign status_byte[`SHP_ST_IE_B] = q.irq_en_b;
  assign status_byte[`SHP_ST_IRQ_A] = irq_request_a;
  assign status_byte[`SHP_ST_IE_A_IN] = q.irq_en_a_in;
  assign status_byte[`SHP_ST_FULL_A] = q.grp_a.in_full;
  assign status_byte[`SHP_ST_IE_A_OUT] = q.irq_en_a_out;
  assign status_byte[`SHP_ST_OUT_FULL_N_A] = q.grp_a.out_full_n;

  // Control word reads back with the mode-set bit high
  assign ctrl_byte = {1'b1, q.mode_a, q.a_input, 1'b0,
    (q.mode_b == shp_pkg::SHP_MODE_STROBED), q.b_input, 1'b0};

  // Basic input reads the live pins; the other modes read the latches
  always_comb
  begin
    rd_byte = 8'h00;
    case (wb_adr)
      `SHP_OFF_PORT_A:
      begin
        if (q.mode_a == shp_pkg::SHP_MODE_BASIC)
        begin
          rd_byte = q.a_input ? pa_in : q.grp_a.out_lat;
        end
        else
        begin
          rd_byte = a_in_path ? q.grp_a.in_lat : q.grp_a.out_lat;
        end
      end
      `SHP_OFF_PORT_B:
      begin
        if (q.mode_b == shp_pkg::SHP_MODE_BASIC)
        begin
          rd_byte = q.b_input ? pb_in : q.grp_b.out_lat;
        end
        else
        begin
          rd_byte = b_in_path ? q.grp_b.in_lat : q.grp_b.out_lat;
        end
      end
      `SHP_OFF_STATUS: rd_byte = status_byte;
      `SHP_OFF_CTRL: rd_byte = ctrl_byte;
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================
  // Next state
  always_comb
  begin
    d = q;
    // One wait state; ack drops in the cycle after it was given
    d.ack = bus_req & ~q.ack;
    if (bus_first & ~wb_we)
    begin
      d.rdata = {24'h000000, rd_byte};
    end

    // Output latches take host writes in every mode [RULE2]
    if (wr_rise_a)
    begin
      d.grp_a.out_lat = host_byte;
    end
    if (wr_rise_b)
    begin
      d.grp_b.out_lat = host_byte;
    end

    // Group A input: pins follow while the strobe is low [RULE3] [RULE18]
    if (a_in_path)
    begin
      if (strobe_low_a)
      begin
        d.grp_a.in_lat = pa_in;
      end
      // Input-full: strobe sets, read rise clears, set wins [RULE4] [RULE18]
      if (strobe_low_a)
      begin
        d.grp_a.in_full = 1'b1;
      end
      else if (rd_rise_a)
      begin
        d.grp_a.in_full = 1'b0;
      end
      // Strobe rise raises the cause only when enabled [RULE5] [RULE13]
      if (strobe_rise_a & q.irq_en_a_in)
      begin
        d.grp_a.strobe_src = 1'b1;
      end
      else if (clr_strobe_a)
      begin
        d.grp_a.strobe_src = 1'b0;
      end
    end

    // Group A output: latch is loaded at the output-full fall [RULE7] [RULE8] [RULE15]
    if (a_out_path)
    begin
      if (wr_rise_a)
      begin
        d.grp_a.out_full_n = 1'b0;
      end
      else if (ack_low_a)
      begin
        d.grp_a.out_full_n = 1'b1;
      end
      // Ack rise raises the cause only when enabled [RULE11] [RULE13]
      if (ack_rise_a & q.irq_en_a_out)
      begin
        d.grp_a.ack_src = 1'b1;
      end
      else if (clr_ack_a)
      begin
        d.grp_a.ack_src = 1'b0;
      end
    end

    // Remembers a finished write pulse for the double-cause clear [RULE14]
    if (wr_rise_a)
    begin
      d.grp_a.wr_done = 1'b1;
    end
    else if (rd_fall_a | wr_fall_a)
    begin
      d.grp_a.wr_done = 1'b0;
    end

    // Group B input [RULE3] [RULE4] [RULE5]
    if (b_in_path)
    begin
      if (strobe_low_b)
      begin
        d.grp_b.in_lat = pb_in;
        d.grp_b.in_full = 1'b1;
      end
      else if (rd_rise_b)
      begin
        d.grp_b.in_full = 1'b0;
      end
      if (strobe_rise_b & q.irq_en_b)
      begin
        d.grp_b.strobe_src = 1'b1;
      end
      else if (rd_fall_b)
      begin
        d.grp_b.strobe_src = 1'b0;
      end
    end

    // Group B output [RULE7] [RULE11]
    if (b_out_path)
    begin
      if (wr_rise_b)
      begin
        d.grp_b.out_full_n = 1'b0;
      end
      else if (ack_low_b)
      begin
        d.grp_b.out_full_n = 1'b1;
      end
      if (ack_rise_b & q.irq_en_b)
      begin
        d.grp_b.ack_src = 1'b1;
      end
      else if (wr_fall_b)
      begin
        d.grp_b.ack_src = 1'b0;
      end
    end

    // Control writes come last so that a mode change wins over handshakes
    if (ctrl_wr & host_byte[`SHP_CW_MODE_SET])
    begin
      case (host_byte[`SHP_CW_A_MODE_HI:`SHP_CW_A_MODE_LO])
        2'h0: d.mode_a = shp_pkg::SHP_MODE_BASIC;
        2'h1: d.mode_a = shp_pkg::SHP_MODE_STROBED;
        default: d.mode_a = shp_pkg::SHP_MODE_BIDIR;
      endcase
      d.a_input = host_byte[`SHP_CW_A_INPUT];
      d.mode_b = host_byte[`SHP_CW_B_MODE] ? shp_pkg::SHP_MODE_STROBED
        : shp_pkg::SHP_MODE_BASIC;
      d.b_input = host_byte[`SHP_CW_B_INPUT];
      // Every mode selection clears the enables and the flags [RULE20]
      d.irq_en_a_in = 1'b0;
      d.irq_en_a_out = 1'b0;
      d.irq_en_b = 1'b0;
      d.grp_a.in_full = 1'b0;
      d.grp_a.out_full_n = 1'b1;
      d.grp_a.strobe_src = 1'b0;
      d.grp_a.ack_src = 1'b0;
      d.grp_a.wr_done = 1'b0;
      d.grp_b.in_full = 1'b0;
      d.grp_b.out_full_n = 1'b1;
      d.grp_b.strobe_src = 1'b0;
      d.grp_b.ack_src = 1'b0;
      d.grp_b.wr_done = 1'b0;
    end
    else if (ctrl_wr)
    begin
      // Enables are reachable only by bit set/reset [RULE6] [RULE17] [RULE21]
      case (host_byte[`SHP_BSR_IDX_HI:`SHP_BSR_IDX_LO])
        `SHP_CTRL_BIT_TWO: d.irq_en_b = host_byte[`SHP_BSR_VALUE];
        `SHP_CTRL_BIT_FOUR: d.irq_en_a_in = host_byte[`SHP_BSR_VALUE];
        `SHP_CTRL_BIT_SIX: d.irq_en_a_out = host_byte[`SHP_BSR_VALUE];
        default: d.irq_en_b = q.irq_en_b;
      endcase
    end
  end

  // ==========================================
  // State register with synchronous reset
  // Flags come out of reset inactive, ports as inputs [RULE20] [RULE23]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q.ack <= 1'b0;
      q.rdata <= 32'h00000000;
      q.mode_a <= shp_pkg::SHP_MODE_BASIC;
      q.a_input <= `SHP_RESET_INPUT;
      q.mode_b <= shp_pkg::SHP_MODE_BASIC;
      q.b_input <= `SHP_RESET_INPUT;
      q.irq_en_a_in <= 1'b0;
      q.irq_en_a_out <= 1'b0;
      q.irq_en_b <= 1'b0;
      q.grp_a.in_lat <= 8'h00;
      q.grp_a.out_lat <= 8'h00;
      q.grp_a.in_full <= 1'b0;
      q.grp_a.out_full_n <= 1'b1;
      q.grp_a.strobe_src <= 1'b0;
      q.grp_a.ack_src <= 1'b0;
      q.grp_a.wr_done <= 1'b0;
      q.grp_b.in_lat <= 8'h00;
      q.grp_b.out_lat <= 8'h00;
      q.grp_b.in_full <= 1'b0;
      q.grp_b.out_full_n <= 1'b1;
      q.grp_b.strobe_src <= 1'b0;
      q.grp_b.ack_src <= 1'b0;
      q.grp_b.wr_done <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================
  // Outputs
  assign wb_ack = q.ack;
  assign wb_dat_rd = q.rdata;
  assign pa_out = q.grp_a.out_lat;
  assign pb_out = q.grp_b.out_lat;
  assign input_full_a = q.grp_a.in_full;
  assign output_full_n_a = q.grp_a.out_full_n;
  assign input_full_b = q.grp_b.in_full;
  assign output_full_n_b = q.grp_b.out_full_n;

  // Bidirectional port A drives only while ack is low; the sync lag
  // means the drivers follow the pin two cycles late [RULE16]
  always_comb
  begin
    pa_oe = 8'h00;
    if (a_bidir)
    begin
      pa_oe = {8{ack_low_a}};
    end
    else if (~q.a_input)
    begin
      pa_oe = 8'hff;
    end
  end

  // Port B drives whenever it is an output
  assign pb_oe = q.b_input ? 8'h00 : 8'hff;

endmodule : shp_port_ctrl

/* File: design/shp_regs.svh */
`ifndef SHP_REGS_SVH
`define SHP_REGS_SVH

// ==========================================
// Register byte offsets
`define SHP_OFF_PORT_A 8'h00
`define SHP_OFF_PORT_B 8'h04
`define SHP_OFF_STATUS 8'h08
`define SHP_OFF_CTRL 8'h0c

// ==========================================
// Control word fields
`define SHP_CW_MODE_SET 7
`define SHP_CW_A_MODE_HI 6
`define SHP_CW_A_MODE_LO 5
`define SHP_CW_A_INPUT 4
`define SHP_CW_B_MODE 2
`define SHP_CW_B_INPUT 1
`define SHP_BSR_IDX_HI 3
`define SHP_BSR_IDX_LO 1
`define SHP_BSR_VALUE 0

// ==========================================
// Bit set/reset positions of the enables
`define SHP_CTRL_BIT_TWO 3'h2
`define SHP_CTRL_BIT_FOUR 3'h4
`define SHP_CTRL_BIT_SIX 3'h6

// ==========================================
// Status word positions
`define SHP_ST_IRQ_B 0
`define SHP_ST_FULL_B 1
`define SHP_ST_IE_B 2
`define SHP_ST_IRQ_A 3
`define SHP_ST_IE_A_IN 4
`define SHP_ST_FULL_A 5
`define SHP_ST_IE_A_OUT 6
`define SHP_ST_OUT_FULL_N_A 7

// ==========================================
// Reset values and widths
`define SHP_PORT_W 8
`define SHP_SYNC_IDLE 1'b1
`define SHP_RESET_INPUT 1'b1

`endif

/* File: design/shp_sync_edge.sv */
`timescale 1ns/1ps
`include "shp_regs.svh"

module shp_sync_edge #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // ==========================================
  // State: two synchroniser stages and a history stage
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } shp_sync_type;

  shp_sync_type q;
  shp_sync_type d;

  // Shift the pins through; only s2 and s3 are looked at
  always_comb
  begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  // Idle high so reset release makes no false edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q.s1 <= {W{`SHP_SYNC_IDLE}};
      q.s2 <= {W{`SHP_SYNC_IDLE}};
      q.s3 <= {W{`SHP_SYNC_IDLE}};
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================
  // Per-line edge detection
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_line
      assign level[i] = q.s2[i];
      assign rise[i] = q.s2[i] & ~q.s3[i];
      assign fall[i] = ~q.s2[i] & q.s3[i];
    end
  endgenerate

endmodule : shp_sync_edge
